// ===== hw/spi_port_map.svh
// Register offsets, field positions, reset values and rate counts
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
`define SPI_CTRL_OFS 12'h000
`define SPI_DATA_OFS 12'h004
`define SPI_MODE_OFS 12'h008
`define SPI_CTRL_RESET 8'h60
`define SPI_MODE_RESET 8'h00
`define CTRL_CKS 7
`define CTRL_ROLE_HI 6
`define CTRL_ROLE_LO 5
`define CTRL_EN 4
`define CTRL_ORDER 3
`define CTRL_SELEN 2
`define CTRL_COLL 1
`define CTRL_DONE 0
`define MODE_POL 4
`define MODE_COLL 5
`define MODE_SEL 6
`define ROLE_SLAVE 2'h3
`define HALF_R0 5'h01
`define HALF_R1_FAST 5'h02
`define HALF_R1_SLOW 5'h04
`define HALF_R2_FAST 5'h08
`define HALF_R2_SLOW 5'h10
`endif

// ===== hw/spi_port_pkg.sv
// Types shared by the serial port and its bench
package spi_port_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_INIT = 4'h2,
    ST_IDLE = 4'h4,
    ST_XFER = 4'h8
  } state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic sck;
    logic serial_in_pin;
    logic serial_out_pin;
    logic sel;
  } pins_t;
endpackage

// ===== hw/spi_master_slave_port.sv
// Byte-wide serial port with master and slave roles behind an APB slave
//
// Behaviour
// - Base clock is system clock halved when source bit 0, undivided when 1.
// - Role field 00/01/10 master at system/2 (either base), base/4, base/16; 11 is slave.
// - On enable rising, drive clock, data-in, data-out, select low, then wait.
// - Master: data write loads buffer and starts full-duplex transfer with clock.
// - Slave: shift buffer on received clock, qualified by select when enabled.
// - Completion copies buffer to readable data; writes go to buffer only.
// - Completion sets done flag bit 0; reads 0 during transfer; software clears.
// - Data write during transfer is ignored and sets collision bit 1.
// - Collision flag works only while collision option bit is set.
// - Bit 3 picks order: 1 most significant first, 0 least first.
// - Select enabled: master drives select, slave uses it; else pin floats.
// - Master asserts select before clocks; slave waits for select.
// - Select option clear forces select-enable to read as disabled.
// - Enabled port owns the four pins, drops pull-ups, drives select low.
// - Standby: data-out high, data-in floats, master clock idles at polarity.
// - Port disabled floats all pins, frees them, clears all flags.
// - Polarity option 1 uses inverted clock timing, 0 the plain one.
// - Transfers keep running while the processor is powered down.
// - Mode bit 4 holds clock polarity option, reset 0.
// - Mode bit 5 enables collision flag, reset 0.
// - Mode bit 6 enables select-enable function, reset 0.
`include "spi_port_map.svh"

module spi_master_slave_port (
  input wire logic mclk,
  input wire logic rst,
  input wire spi_port_pkg::apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spi_port_pkg::pins_t pinIn,
  output spi_port_pkg::pins_t pinOut,
  output spi_port_pkg::pins_t pinOe,
  output logic pinFunction,
  output logic serialPortIrq
);
  spi_port_pkg::state_t state_q;
  spi_port_pkg::state_t state_d;
  spi_port_pkg::pins_t pinOut_q;
  spi_port_pkg::pins_t pinOe_q;
  logic [7:2] ctrl_q;
  logic collOpt_q;
  logic selOpt_q;
  logic polOpt_q;
  logic done_q;
  logic done_d;
  logic coll_q;
  logic irq_q;
  logic [7:0] txBuf_q;
  logic [7:0] txBuf_d;
  logic [7:0] rxData_q;
  logic rxBit_q;
  logic [2:0] bitCnt_q;
  logic [4:0] halfCnt_q;
  logic [4:0] halfLen;
  logic sckPrev_q;
  logic loaded_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic func_q;
  logic [7:0] xferCycles_q;

  logic portEn, isSlave, isMaster, msbFirst, selEnEff, setup, apbWrite, ctrlWr, dataWr;
  logic modeWr, busy, loadData, halfTick, masterLead, masterTrail, slaveSel, slaveLead;
  logic slaveTrail, lead, trail, xferEnd, start, collSet;
  logic [7:0] ctrlRead;

  assign portEn = ctrl_q[`CTRL_EN];
  assign isSlave = ctrl_q[`CTRL_ROLE_HI:`CTRL_ROLE_LO] == `ROLE_SLAVE;
  assign isMaster = !isSlave;
  assign msbFirst = ctrl_q[`CTRL_ORDER];
  assign selEnEff = ctrl_q[`CTRL_SELEN] & selOpt_q;
  assign busy = state_q == spi_port_pkg::ST_XFER;

  // APB decode
  assign setup = apbReq.psel & !apbReq.penable;
  assign apbWrite = apbReq.psel & apbReq.penable & apbReq.pwrite & pready_q;
  assign ctrlWr = apbWrite && apbReq.paddr == `SPI_CTRL_OFS;
  assign dataWr = apbWrite && apbReq.paddr == `SPI_DATA_OFS;
  assign modeWr = apbWrite && apbReq.paddr == `SPI_MODE_OFS;

  // Half serial clock period in system cycles
  always_comb begin
    unique case (ctrl_q[`CTRL_ROLE_HI:`CTRL_ROLE_LO])
      2'h0: halfLen = `HALF_R0;
      2'h1: halfLen = ctrl_q[`CTRL_CKS] ? `HALF_R1_FAST : `HALF_R1_SLOW;
      2'h2: halfLen = ctrl_q[`CTRL_CKS] ? `HALF_R2_FAST : `HALF_R2_SLOW;
      2'h3: halfLen = `HALF_R0;
    endcase
  end

  // Serial edge events; nothing here is gated by processor power state
  assign halfTick = busy && isMaster && halfCnt_q == halfLen - 5'h01;
  assign masterLead = halfTick && pinOut_q.sck == polOpt_q;
  assign masterTrail = halfTick && pinOut_q.sck != polOpt_q;
  assign slaveSel = !selEnEff || !pinIn.sel;
  assign slaveLead = isSlave && slaveSel && (busy || state_q == spi_port_pkg::ST_IDLE)
    && sckPrev_q == polOpt_q && pinIn.sck != polOpt_q;
  assign slaveTrail = isSlave && slaveSel && busy
    && sckPrev_q != polOpt_q && pinIn.sck == polOpt_q;
  assign lead = masterLead | slaveLead;
  assign trail = masterTrail | slaveTrail;
  assign xferEnd = trail && bitCnt_q == 3'h7;

  assign loadData = dataWr && state_q == spi_port_pkg::ST_IDLE;
  assign start = state_q == spi_port_pkg::ST_IDLE
    && ((loadData && isMaster) || slaveLead);
  assign collSet = dataWr && busy && collOpt_q;

  // Port state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      spi_port_pkg::ST_OFF: begin
        if (portEn) begin
          state_d = spi_port_pkg::ST_INIT;
        end
      end
      spi_port_pkg::ST_INIT: state_d = spi_port_pkg::ST_IDLE;
      spi_port_pkg::ST_IDLE: begin
        if (start) begin
          state_d = spi_port_pkg::ST_XFER;
        end
      end
      spi_port_pkg::ST_XFER: begin
        if (xferEnd) begin
          state_d = spi_port_pkg::ST_IDLE;
        end
      end
      default: state_d = spi_port_pkg::ST_OFF;
    endcase
    if (!portEn) begin
      state_d = spi_port_pkg::ST_OFF;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= spi_port_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Control and mode registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= 6'(`SPI_CTRL_RESET >> 2);
    end else if (ctrlWr) begin
      ctrl_q <= apbReq.pwdata[7:2];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      polOpt_q <= 1'(`SPI_MODE_RESET >> `MODE_POL);
      collOpt_q <= 1'(`SPI_MODE_RESET >> `MODE_COLL);
      selOpt_q <= 1'(`SPI_MODE_RESET >> `MODE_SEL);
    end else if (modeWr) begin
      polOpt_q <= apbReq.pwdata[`MODE_POL];
      collOpt_q <= apbReq.pwdata[`MODE_COLL];
      selOpt_q <= apbReq.pwdata[`MODE_SEL];
    end
  end

  // Done flag: set beats the start and write clears, disable clear beats set, cleared by writing 0
  always_comb begin
    done_d = done_q;
    if (!portEn) begin
      done_d = 1'b0;
    end else if (xferEnd) begin
      done_d = 1'b1;
    end else if (start) begin
      done_d = 1'b0;
    end else if (ctrlWr && !apbReq.pwdata[`CTRL_DONE]) begin
      done_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      done_q <= done_d;
      irq_q <= done_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      coll_q <= 1'b0;
    end else if (!portEn) begin
      coll_q <= 1'b0;
    end else if (collSet) begin
      coll_q <= 1'b1;
    end else if (ctrlWr && !apbReq.pwdata[`CTRL_COLL]) begin
      coll_q <= 1'b0;
    end
  end

  // Transfer buffer and shift
  always_comb begin
    txBuf_d = txBuf_q;
    if (loadData) begin
      txBuf_d = apbReq.pwdata[7:0];
    end else if (trail) begin
      txBuf_d = msbFirst ? {txBuf_q[6:0], rxBit_q} : {rxBit_q, txBuf_q[7:1]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      txBuf_q <= 8'h00;
      rxBit_q <= 1'b0;
    end else begin
      txBuf_q <= txBuf_d;
      if (lead) begin
        rxBit_q <= pinIn.serial_in_pin;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rxData_q <= 8'h00;
    end else if (xferEnd) begin
      rxData_q <= txBuf_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bitCnt_q <= 3'h0;
    end else if (!busy) begin
      bitCnt_q <= 3'h0;
    end else if (trail) begin
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      halfCnt_q <= 5'h00;
    end else if (!busy || !isMaster || halfTick) begin
      halfCnt_q <= 5'h00;
    end else begin
      halfCnt_q <= halfCnt_q + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sckPrev_q <= 1'b0;
    end else begin
      sckPrev_q <= pinIn.sck;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      loaded_q <= 1'b0;
    end else if (!portEn || start || xferEnd) begin
      loaded_q <= 1'b0;
    end else if (loadData) begin
      loaded_q <= 1'b1;
    end
  end

  // Pin drivers
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinOut_q <= '0;
      pinOe_q <= '0;
      func_q <= 1'b0;
    end else begin
      unique case (state_d)
        spi_port_pkg::ST_OFF: begin
          pinOut_q <= '0;
          pinOe_q <= '0;
          func_q <= 1'b0;
        end
        spi_port_pkg::ST_INIT: begin
          pinOut_q <= '0;
          pinOe_q <= '1;
          func_q <= 1'b1;
        end
        default: begin
          func_q <= 1'b1;
          pinOut_q.serial_in_pin <= 1'b0;
          pinOe_q.serial_in_pin <= 1'b0;
          pinOe_q.serial_out_pin <= 1'b1;
          if (state_d == spi_port_pkg::ST_XFER || loaded_q || loadData) begin
            pinOut_q.serial_out_pin <= msbFirst ? txBuf_d[7] : txBuf_d[0];
          end else begin
            pinOut_q.serial_out_pin <= 1'b1;
          end
          pinOe_q.sck <= isMaster;
          if (isMaster && state_d == spi_port_pkg::ST_XFER && halfTick) begin
            pinOut_q.sck <= ~pinOut_q.sck;
          end else if (isMaster && state_d == spi_port_pkg::ST_XFER) begin
            pinOut_q.sck <= pinOut_q.sck;
          end else begin
            pinOut_q.sck <= isMaster & polOpt_q;
          end
          pinOut_q.sel <= 1'b0;
          pinOe_q.sel <= selEnEff & isMaster;
        end
      endcase
    end
  end

  // APB answer: zero wait states, data prepared during setup
  assign ctrlRead = {ctrl_q[7:3], selEnEff, coll_q & collOpt_q, done_q};

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (setup) begin
        unique case (apbReq.paddr)
          `SPI_CTRL_OFS: prdata_q <= {24'h000000, ctrlRead};
          `SPI_DATA_OFS: prdata_q <= {24'h000000, rxData_q};
          `SPI_MODE_OFS: prdata_q <= {25'h0000000, selOpt_q, collOpt_q, polOpt_q, 4'h0};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign pinFunction = func_q;
  assign serialPortIrq = irq_q;

  // Checks
  always_ff @(posedge mclk) begin
    if (rst || !busy) begin
      xferCycles_q <= 8'h00;
    end else begin
      xferCycles_q <= xferCycles_q + 8'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sMasterEnd;
    xferEnd && isMaster;
  endsequence

  sequence sInitStep;
    state_q == spi_port_pkg::ST_OFF && portEn;
  endsequence

  a_done_set: assert property (xferEnd && portEn |=> done_q && serialPortIrq)
    else $error("done flag not set after transfer");
  a_irq_follow: assert property (serialPortIrq == done_q)
    else $error("interrupt differs from done flag");
  a_coll_set: assert property (collSet && portEn |=> coll_q)
    else $error("collision not flagged");
  a_coll_gate: assert property ($rose(coll_q) |-> $past(collOpt_q))
    else $error("collision set while option off");
  a_init_low: assert property (sInitStep |=> pinOe == 4'hF && pinOut == 4'h0)
    else $error("pins not driven low on enable");
  a_off_float: assert property ((!portEn)[*2] |-> pinOe == 4'h0 && !done_q)
    else $error("disabled port still drives pins");
  a_master_len: assert property (sMasterEnd |-> {1'b0, xferCycles_q} ==
    ({4'h0, halfLen} << 4) - 9'h001)
    else $error("master transfer length wrong");
  a_data_latch: assert property (xferEnd |=> rxData_q == $past(txBuf_d))
    else $error("received byte not latched");
  a_sel_read: assert property (setup && apbReq.paddr == `SPI_CTRL_OFS && !selOpt_q
    |=> !prdata[`CTRL_SELEN])
    else $error("select enable reads set while option off");
  a_sdo_idle: assert property ((state_q == spi_port_pkg::ST_IDLE && !loaded_q)[*2]
    |-> pinOut.serial_out_pin && !pinOe.serial_in_pin)
    else $error("standby data-out not high");
endmodule

// ===== verification/spi_peripheral_model.sv
// Serial peripheral model facing the port pins
module spi_peripheral_model (
  input wire logic mclk,
  input wire logic arm,
  input wire logic sck,
  input wire logic mosi,
  input wire logic pol,
  input wire logic msbFirst,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sckQ = 1'h0;
  logic idleQ = 1'h0;
  logic [3:0] cnt = 4'h8;
  logic [3:0] pos;
  // A trailing edge not yet counted already moves the outgoing bit on
  assign pos = cnt + {3'h0, sck != sckQ && sck == pol && !cnt[3]};
  // Bit stands before the leading edge; a changing pattern once the byte is done
  assign miso = pos[3] ? idleQ : txByte[msbFirst ? 3'h7 - pos[2:0] : pos[2:0]];
  always @(posedge mclk) begin
    sckQ <= sck;
    idleQ <= ~idleQ;
    if (arm)
      cnt <= 4'h0;
    else if (sck != sckQ && sck == pol && !cnt[3])
      cnt <= cnt + 4'h1;
    if (sck != sckQ && sck != pol)
      rxByte <= msbFirst ? {rxByte[6:0], mosi} : {mosi, rxByte[7:1]};
  end
endmodule

// ===== verification/spi_master_slave_port_tb.sv
// Self-checking bench for the serial port
`include "spi_port_map.svh"
module spi_master_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  spi_port_pkg::apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pinFunction, serialPortIrq, miso;
  spi_port_pkg::pins_t pinIn, pinOut, pinOe;
  logic tbSck = 1'h0, tbSel = 1'h1, arm = 1'h0, pol = 1'h0, msb = 1'h0;
  logic [7:0] txByte = 8'h00, rxByte;
  logic [32:0] expQ[$];
  int errCount = 0, nCompared = 0, cyc = 0;
  assign pinIn = {pinOe.sck ? pinOut.sck : tbSck, pinOe.serial_in_pin ? pinOut.serial_in_pin : miso,
    pinOe.serial_out_pin ? pinOut.serial_out_pin : 1'h1, pinOe.sel ? pinOut.sel : tbSel};
  spi_master_slave_port uut (.mclk(mclk), .rst(rst), .apbReq(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinFunction(pinFunction), .serialPortIrq(serialPortIrq));
  spi_peripheral_model peer (.mclk(mclk), .arm(arm), .sck(pinIn.sck), .mosi(pinIn.serial_out_pin),
    .pol(pol), .msbFirst(msb), .txByte(txByte), .miso(miso), .rxByte(rxByte));
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    req <= '{1'h1, 1'h0, w, a, {24'h0, d}};
    @(posedge mclk);
    req.penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'h0);
    expQ.push_back({err, 24'h0, e});
    apb(1'h0, a, 8'h00);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      tbSck <= 1'h1;
      repeat (4) @(posedge mclk);
      tbSck <= 1'h0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // Read results are matched against the oldest noted expectation
  always @(posedge mclk) begin
    if (req.psel && req.penable && !req.pwrite && pready === 1'h1)
      check("read data", {pslverr, prdata}, expQ.pop_front());
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    endOfTest();
  end
  initial begin
    logic [7:0] ctl, tx;
    logic [1:0] role;
    logic base_clock_select, selOpt, collOpt;
    int h, t0;
    void'($urandom(23));
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rd(`SPI_CTRL_OFS, `SPI_CTRL_RESET);
    rd(`SPI_MODE_OFS, `SPI_MODE_RESET);
    rd(12'h00C, 8'h00, 1'h1);
    check("pins at reset", {pinOe, pinFunction}, 5'h00);
    for (int i = 0; i < 6; i++) begin
      role = 2'(i / 2);
      base_clock_select = i[0];
      collOpt = i[1] ^ i[2];
      selOpt = i != 1;
      h = role == 0 ? 1 : (base_clock_select ? 1 : 2) << (2 * role - 1);
      ctl = {base_clock_select, role, 1'h1, i[0] ^ i[1], 1'h1, 2'h0};
      pol <= i[1];
      msb <= i[0] ^ i[1];
      wr(`SPI_CTRL_OFS, 8'h00);
      wr(`SPI_MODE_OFS, {1'h0, selOpt, collOpt, i[1], 4'h0});
      wr(`SPI_CTRL_OFS, ctl);
      repeat (3) @(posedge mclk);
      check("standby", {pinOut.sck, pinOut.serial_out_pin, pinOe.serial_in_pin, pinOe.serial_out_pin, pinFunction}, {i[1], 4'hB});
      check("select", {pinOe.sel, pinOut.sel}, {selOpt, 1'h0});
      tx = 8'($urandom);
      txByte <= 8'($urandom);
      arm <= 1'h1;
      @(posedge mclk);
      arm <= 1'h0;
      wr(`SPI_DATA_OFS, tx);
      t0 = cyc;
      wr(`SPI_DATA_OFS, ~tx);
      rd(`SPI_CTRL_OFS, {ctl[7:3], selOpt, collOpt, 1'h0});
      while (serialPortIrq !== 1'h1 && cyc - t0 < 600) @(posedge mclk);
      check("transfer time", cyc - t0, 16 * h);
      rd(`SPI_CTRL_OFS, {ctl[7:3], selOpt, collOpt, 1'h1});
      rd(`SPI_DATA_OFS, txByte);
      check("peer byte", rxByte, tx);
      if (i < 5) begin
        wr(`SPI_CTRL_OFS, ctl);
        check("irq cleared", serialPortIrq, 1'h0);
      end
    end
    wr(`SPI_CTRL_OFS, 8'h00);
    @(posedge mclk);
    check("disabled", {serialPortIrq, pinOe, pinFunction}, 6'h00);
    rd(`SPI_CTRL_OFS, 8'h00);
    pol <= 1'h0;
    msb <= 1'h1;
    wr(`SPI_MODE_OFS, 8'h40);
    wr(`SPI_CTRL_OFS, 8'h7C);
    tx = 8'($urandom);
    txByte <= 8'($urandom);
    wr(`SPI_DATA_OFS, tx);
    pulse(2);
    rd(`SPI_CTRL_OFS, 8'h7C);
    arm <= 1'h1;
    tbSel <= 1'h0;
    @(posedge mclk);
    arm <= 1'h0;
    pulse(8);
    rd(`SPI_CTRL_OFS, 8'h7D);
    rd(`SPI_DATA_OFS, txByte);
    check("slave byte", rxByte, tx);
    endOfTest();
  end
endmodule
